// [logic/adc_calibration_sequencer.sv]
// calibration sequencer: foreground, background and low-power core rotation, offset trims
`timescale 1ns/100ps
module adc_calibration_sequencer #(
  parameter int SAMPLE_W = 12,
  parameter int CAL_CYCLES = 64,
  parameter int OFFSET_CAL_CYCLES = 256,
  parameter logic [11:0] FACTORY_TRIM_FIRST = 12'h000,
  parameter logic [11:0] FACTORY_TRIM_SECOND = 12'h000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // trigger pin
  input wire logic cal_trigger_pin,
  // converter cores
  input wire logic [SAMPLE_W-1:0] sample_core_a,
  input wire logic [SAMPLE_W-1:0] sample_core_b,
  input wire logic [SAMPLE_W-1:0] sample_core_c,
  input wire logic [11:0] offset_estimate_first,
  input wire logic [11:0] offset_estimate_second,
  output logic [2:0] core_power_on,
  output logic [2:0] core_cal_active,
  output logic [2:0] core_input_sel,
  // sample and trim outputs
  output logic [SAMPLE_W-1:0] data_out_first,
  output logic [SAMPLE_W-1:0] data_out_second,
  output logic [11:0] input_offset_trim_first,
  output logic [11:0] input_offset_trim_second
);
  if (SAMPLE_W < 2 || CAL_CYCLES < 1 || CAL_CYCLES > 16384 || OFFSET_CAL_CYCLES < 1
      || OFFSET_CAL_CYCLES > 16384) begin : g_bad_param
    $error("adc_calibration_sequencer: parameter out of range");
  end

  localparam logic [15:0] CAL_LAST = 16'(CAL_CYCLES - 1);
  localparam logic [15:0] FOREGROUND_OFFSET_CAL_ENABLE_LAST = 16'(CAL_CYCLES + OFFSET_CAL_CYCLES - 1);
  localparam logic [15:0] OFF_LAST = 16'(OFFSET_CAL_CYCLES - 1);
  localparam logic [7:0] TICK_LAST = 8'(cal_seq_pkg::DELAY_TICK_CYCLES - 1);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  function automatic logic addr_mapped(input logic [7:0] a);
    return a == cal_seq_pkg::ADDR_CTRL || a == cal_seq_pkg::ADDR_TRIGGER
      || a == cal_seq_pkg::ADDR_DELAY || a == cal_seq_pkg::ADDR_STATUS
      || a == cal_seq_pkg::ADDR_TRIM_FIRST || a == cal_seq_pkg::ADDR_TRIM_SECOND;
  endfunction : addr_mapped

  function automatic logic [SAMPLE_W-1:0] pick_core(input logic [1:0] c,
      input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b,
      input logic [SAMPLE_W-1:0] s);
    case (c)
      cal_seq_pkg::CORE_A: return a;
      cal_seq_pkg::CORE_B: return b;
      default: return s;
    endcase
  endfunction : pick_core

  logic [8:0] ctrl_reg;
  logic soft_trig_reg;
  logic [31:0] delay_reg;
  logic [11:0] trim_first_reg;
  logic [11:0] trim_second_reg;
  logic foreground_cal_complete_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic pin_prev_reg;
  logic [7:0] tick_cnt_reg;
  logic [15:0] cnt_reg;
  logic [1:0] slot_a_reg;
  logic [1:0] slot_b_reg;
  logic [1:0] spare_reg;
  logic victim_b_reg;
  cal_seq_pkg::cal_state_t state_reg;
  cal_seq_pkg::cal_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////////
  // register bus: write and read accepted together with address, answer next cycle
  logic wr_go;
  logic rd_go;
  logic [31:0] wr_ctrl;
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
  assign rd_go = s_axi_arvalid & ~rvalid_reg;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign wr_ctrl = merge_bytes({23'h0, ctrl_reg}, s_axi_wdata, s_axi_wstrb);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= cal_seq_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= addr_mapped(s_axi_awaddr) ? cal_seq_pkg::RESP_OKAY : cal_seq_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= cal_seq_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= addr_mapped(s_axi_araddr) ? cal_seq_pkg::RESP_OKAY : cal_seq_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        cal_seq_pkg::ADDR_CTRL: rdata_reg <= {23'h0, ctrl_reg};
        cal_seq_pkg::ADDR_TRIGGER: rdata_reg <= {31'h0, soft_trig_reg};
        cal_seq_pkg::ADDR_DELAY: rdata_reg <= delay_reg;
        cal_seq_pkg::ADDR_STATUS: rdata_reg <= {21'h0, victim_b_reg, state_reg, spare_reg,
                                                slot_b_reg, slot_a_reg, foreground_cal_complete_reg};
        cal_seq_pkg::ADDR_TRIM_FIRST: rdata_reg <= {20'h0, trim_first_reg};
        cal_seq_pkg::ADDR_TRIM_SECOND: rdata_reg <= {20'h0, trim_second_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control registers and trigger events
  logic wr_ctrl_hit;
  logic wr_trig_hit;
  logic soft_rise;
  logic pin_rise;
  logic cal_en_rise;
  logic fg_start;
  logic swap_event;
  logic offset_cal_on;
  assign wr_ctrl_hit = wr_go && s_axi_awaddr == cal_seq_pkg::ADDR_CTRL;
  assign wr_trig_hit = wr_go && s_axi_awaddr == cal_seq_pkg::ADDR_TRIGGER && s_axi_wstrb[0];
  assign soft_rise = wr_trig_hit && s_axi_wdata[0] && !soft_trig_reg;
  assign pin_rise = cal_trigger_pin && !pin_prev_reg;
  assign cal_en_rise = wr_ctrl_hit && wr_ctrl[cal_seq_pkg::CTRL_CAL_EN]
                       && !ctrl_reg[cal_seq_pkg::CTRL_CAL_EN];
  // the enable-rise term is gated by the old enable, so raising the enable alone never starts a run
  assign fg_start = ctrl_reg[cal_seq_pkg::CTRL_CAL_EN] && (cal_en_rise
      || (ctrl_reg[cal_seq_pkg::CTRL_SRC_SEL] ? pin_rise : soft_rise));
  assign swap_event = pin_rise || soft_rise;
  assign offset_cal_on = ctrl_reg[cal_seq_pkg::CTRL_FG_OS] || ctrl_reg[cal_seq_pkg::CTRL_BG_OS];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_reg <= cal_seq_pkg::CTRL_RESET;
      soft_trig_reg <= 1'b0;
      delay_reg <= cal_seq_pkg::DELAY_RESET;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= cal_trigger_pin;
      if (wr_ctrl_hit) begin
        ctrl_reg <= wr_ctrl[cal_seq_pkg::CTRL_W-1:0];
      end
      if (wr_trig_hit) begin
        soft_trig_reg <= s_axi_wdata[0];
      end
      if (wr_go && s_axi_awaddr == cal_seq_pkg::ADDR_DELAY) begin
        delay_reg <= merge_bytes(delay_reg, s_axi_wdata, s_axi_wstrb);
      end
    end
  end

  // host trim writes are dropped while the offset engine owns the trims
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      trim_first_reg <= FACTORY_TRIM_FIRST;
      trim_second_reg <= FACTORY_TRIM_SECOND;
    end else if ((state_reg == cal_seq_pkg::ST_FG_OFFSET && cnt_reg == OFF_LAST)
        || (state_reg == cal_seq_pkg::ST_BG_CAL && cnt_reg == FOREGROUND_OFFSET_CAL_ENABLE_LAST
            && ctrl_reg[cal_seq_pkg::CTRL_BG_OS])) begin
      trim_first_reg <= offset_estimate_first;
      trim_second_reg <= offset_estimate_second;
    end else if (wr_go && !offset_cal_on) begin
      if (s_axi_awaddr == cal_seq_pkg::ADDR_TRIM_FIRST) begin
        trim_first_reg <= 12'(merge_bytes({20'h0, trim_first_reg}, s_axi_wdata, s_axi_wstrb));
      end
      if (s_axi_awaddr == cal_seq_pkg::ADDR_TRIM_SECOND) begin
        trim_second_reg <= 12'(merge_bytes({20'h0, trim_second_reg}, s_axi_wdata, s_axi_wstrb));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer
  logic bg_en;
  logic low_power_bg_enable;
  logic tick;
  assign bg_en = ctrl_reg[cal_seq_pkg::CTRL_BG_EN];
  assign low_power_bg_enable = ctrl_reg[cal_seq_pkg::CTRL_LOW_POWER_BG_ENABLE];
  assign tick = tick_cnt_reg == TICK_LAST;

  always_ff @(posedge ref_clk) begin
    if (reset || tick) begin
      tick_cnt_reg <= 8'h00;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cal_seq_pkg::ST_IDLE: begin
        if (bg_en) begin
          state_next = low_power_bg_enable ? cal_seq_pkg::ST_BG_SLEEP : cal_seq_pkg::ST_BG_CAL;
        end else if (fg_start) begin
          state_next = cal_seq_pkg::ST_FG_CAL;
        end
      end
      cal_seq_pkg::ST_FG_CAL: begin
        if (cnt_reg == CAL_LAST) begin
          state_next = ctrl_reg[cal_seq_pkg::CTRL_FG_OS] ? cal_seq_pkg::ST_FG_OFFSET
                                                         : cal_seq_pkg::ST_IDLE;
        end
      end
      cal_seq_pkg::ST_FG_OFFSET: begin
        if (cnt_reg == OFF_LAST) begin
          state_next = cal_seq_pkg::ST_IDLE;
        end
      end
      cal_seq_pkg::ST_BG_SLEEP: begin
        if (!bg_en) begin
          state_next = cal_seq_pkg::ST_IDLE;
        end else if (ctrl_reg[cal_seq_pkg::CTRL_MANUAL] ? swap_event
                     : cnt_reg >= delay_reg[15:0]) begin
          state_next = cal_seq_pkg::ST_BG_WAKE;
        end
      end
      cal_seq_pkg::ST_BG_WAKE: begin
        if (!bg_en) begin
          state_next = cal_seq_pkg::ST_IDLE;
        end else if (cnt_reg >= delay_reg[31:16]) begin
          state_next = cal_seq_pkg::ST_BG_CAL;
        end
      end
      cal_seq_pkg::ST_BG_CAL: begin
        if (!bg_en) begin
          state_next = cal_seq_pkg::ST_IDLE;
        end else if (cnt_reg == (ctrl_reg[cal_seq_pkg::CTRL_BG_OS] ? FOREGROUND_OFFSET_CAL_ENABLE_LAST
                                                                   : CAL_LAST)) begin
          state_next = cal_seq_pkg::ST_BG_SWAP;
        end
      end
      cal_seq_pkg::ST_BG_SWAP: begin
        state_next = !bg_en ? cal_seq_pkg::ST_IDLE
                   : (low_power_bg_enable ? cal_seq_pkg::ST_BG_SLEEP : cal_seq_pkg::ST_BG_CAL);
      end
      default: state_next = cal_seq_pkg::ST_IDLE;
    endcase
  end

  // delays count slow ticks, calibration steps count clock cycles
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= cal_seq_pkg::ST_FG_CAL;
      cnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        cnt_reg <= 16'h0000;
      end else if (tick || state_reg == cal_seq_pkg::ST_FG_CAL
                   || state_reg == cal_seq_pkg::ST_FG_OFFSET
                   || state_reg == cal_seq_pkg::ST_BG_CAL) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || (state_reg == cal_seq_pkg::ST_IDLE && state_next == cal_seq_pkg::ST_FG_CAL)) begin
      foreground_cal_complete_reg <= 1'b0;
    end else if (state_reg != state_next && state_next == cal_seq_pkg::ST_IDLE
                 && (state_reg == cal_seq_pkg::ST_FG_CAL
                     || state_reg == cal_seq_pkg::ST_FG_OFFSET)) begin
      foreground_cal_complete_reg <= 1'b1;
    end
  end

  // the displaced core becomes the spare; slots A and B are replaced alternately
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      slot_a_reg <= cal_seq_pkg::CORE_A;
      slot_b_reg <= cal_seq_pkg::CORE_B;
      spare_reg <= cal_seq_pkg::CORE_C;
      victim_b_reg <= 1'b0;
    end else if (state_reg == cal_seq_pkg::ST_BG_SWAP) begin
      victim_b_reg <= !victim_b_reg;
      spare_reg <= victim_b_reg ? slot_b_reg : slot_a_reg;
      if (victim_b_reg) begin
        slot_b_reg <= spare_reg;
      end else begin
        slot_a_reg <= spare_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // core control and sample path
  logic fg_busy;
  logic spare_awake;
  assign fg_busy = state_reg == cal_seq_pkg::ST_FG_CAL || state_reg == cal_seq_pkg::ST_FG_OFFSET;
  // without low-power the spare stays up for the whole background run
  assign spare_awake = bg_en && (!low_power_bg_enable || state_reg == cal_seq_pkg::ST_BG_WAKE
      || state_reg == cal_seq_pkg::ST_BG_CAL || state_reg == cal_seq_pkg::ST_BG_SWAP);

  always_comb begin
    for (int c = 0; c < 3; c++) begin
      core_power_on[c] = 2'(c) != spare_reg || spare_awake;
      core_cal_active[c] = fg_busy
          || (state_reg == cal_seq_pkg::ST_BG_CAL && 2'(c) == spare_reg);
      if (ctrl_reg[cal_seq_pkg::CTRL_SINGLE]) begin
        core_input_sel[c] = ctrl_reg[cal_seq_pkg::CTRL_IN_SEL];
      end else if (2'(c) == slot_a_reg) begin
        core_input_sel[c] = 1'b0;
      end else if (2'(c) == slot_b_reg) begin
        core_input_sel[c] = 1'b1;
      end else begin
        core_input_sel[c] = victim_b_reg;
      end
    end
  end

  // each core output already merges its two opposite-phase banks
  always_ff @(posedge ref_clk) begin
    if (reset || fg_busy) begin
      data_out_first <= '0;
      data_out_second <= '0;
    end else begin
      data_out_first <= pick_core(slot_a_reg, sample_core_a, sample_core_b, sample_core_c);
      data_out_second <= pick_core(slot_b_reg, sample_core_a, sample_core_b, sample_core_c);
    end
  end

  assign input_offset_trim_first = trim_first_reg;
  assign input_offset_trim_second = trim_second_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  // run length is counted here, as a delay range cannot reach the longest run
  localparam logic [15:0] FG_RUN_MAX = 16'(CAL_CYCLES + OFFSET_CAL_CYCLES - 1);
  logic [15:0] fg_run_cnt_reg;
  always_ff @(posedge ref_clk) begin
    if (reset || !fg_busy) begin
      fg_run_cnt_reg <= 16'h0000;
    end else begin
      fg_run_cnt_reg <= fg_run_cnt_reg + 16'h0001;
    end
  end

  a_fg_run_bounded: assert property (@(posedge ref_clk) disable iff (reset)
    fg_busy |-> fg_run_cnt_reg <= FG_RUN_MAX)
    else $error("foreground calibration ran too long");

  a_midcode_output: assert property (@(posedge ref_clk) disable iff (reset)
    fg_busy |=> data_out_first == '0 && data_out_second == '0)
    else $error("output not midcode during foreground calibration");

  a_powerup_run: assert property (@(posedge ref_clk)
    reset ##1 !reset |-> state_reg == cal_seq_pkg::ST_FG_CAL && !foreground_cal_complete_reg)
    else $error("no foreground calibration after reset");

  a_trigger_start: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == cal_seq_pkg::ST_IDLE && !bg_en && fg_start
    |=> state_reg == cal_seq_pkg::ST_FG_CAL && !foreground_cal_complete_reg)
    else $error("trigger did not run a foreground calibration");

  a_done_clear: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(fg_busy) |-> !foreground_cal_complete_reg)
    else $error("done flag set while calibration runs");

  a_swap_rotates: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == cal_seq_pkg::ST_BG_SWAP
    |=> spare_reg == $past(victim_b_reg ? slot_b_reg : slot_a_reg) && spare_reg != $past(spare_reg))
    else $error("core rotation did not swap the spare");

  a_spare_asleep: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == cal_seq_pkg::ST_BG_SLEEP && low_power_bg_enable |-> !core_power_on[spare_reg])
    else $error("sleeping spare core powered");

  a_sleep_holds: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == cal_seq_pkg::ST_BG_SLEEP && bg_en && !ctrl_reg[cal_seq_pkg::CTRL_MANUAL]
    && cnt_reg < delay_reg[15:0] |=> state_reg == cal_seq_pkg::ST_BG_SLEEP)
    else $error("spare core woke before sleep delay");

  a_wake_then_cal: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(state_reg == cal_seq_pkg::ST_BG_CAL) && low_power_bg_enable
    |-> $past(state_reg) == cal_seq_pkg::ST_BG_WAKE && $past(cnt_reg) >= delay_reg[31:16])
    else $error("calibration began before wake delay");

  a_manual_swap: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == cal_seq_pkg::ST_BG_SLEEP && bg_en && ctrl_reg[cal_seq_pkg::CTRL_MANUAL]
    && !swap_event |=> state_reg == cal_seq_pkg::ST_BG_SLEEP)
    else $error("manual swap left sleep without a trigger");

  a_trim_locked: assert property (@(posedge ref_clk) disable iff (reset)
    offset_cal_on && state_reg == cal_seq_pkg::ST_IDLE && $stable(ctrl_reg)
    |=> $stable(trim_first_reg) && $stable(trim_second_reg))
    else $error("trim changed by host while offset calibration enabled");

  a_single_input: assert property (@(posedge ref_clk) disable iff (reset)
    ctrl_reg[cal_seq_pkg::CTRL_SINGLE]
    |-> core_input_sel[slot_a_reg] == core_input_sel[slot_b_reg])
    else $error("single channel cores on different inputs");
endmodule : adc_calibration_sequencer

// [shared/cal_seq_pkg.sv]
// constants, register map and state encoding for the calibration sequencer
//
// Notes on behaviour
// - During foreground calibration every output sample is forced to midcode zero.
// - Six banks pair into three cores, two opposite-phase banks per core.
// - Dual channel: core A takes first input, B second; single: both take one.
// - Background mode periodically substitutes the third core for core A or B.
// - Foreground calibration runs at power-up; host waits before configuring.
// - Foreground calibration starts on pin or software trigger, per source select.
// - Background mode rotates cores: spare calibrated, swapped in, displaced core next.
// - Low-power background keeps offline cores powered down until due for calibration.
// - Low-power, automatic swap: sleep delay sets how long spare core sleeps.
// - Wake delay sets how long a woken core settles before calibration.
// - Manual swap select picks automatic swapping or swapping on host trigger.
// - Foreground offset enable adds one offset correction to each foreground run.
// - Background offset enable repeats offset correction inside the background routine.
// - Offset calibration writes offset trims; host must not write them meanwhile.
// - Trims reset to per-device factory values, readable and writable by host.
package cal_seq_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int DELAY_TICK_NS = 1600;
  localparam int DELAY_TICK_CYCLES = (DELAY_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TRIGGER = 8'h04;
  localparam logic [7:0] ADDR_DELAY = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_TRIM_FIRST = 8'h10;
  localparam logic [7:0] ADDR_TRIM_SECOND = 8'h14;

  localparam int CTRL_CAL_EN = 0;
  localparam int CTRL_BG_EN = 1;
  localparam int CTRL_SRC_SEL = 2;
  localparam int CTRL_LOW_POWER_BG_ENABLE = 3;
  localparam int CTRL_MANUAL = 4;
  localparam int CTRL_FG_OS = 5;
  localparam int CTRL_BG_OS = 6;
  localparam int CTRL_SINGLE = 7;
  localparam int CTRL_IN_SEL = 8;
  localparam int CTRL_W = 9;
  localparam logic [8:0] CTRL_RESET = 9'h001;

  localparam logic [31:0] DELAY_RESET = 32'h0010_0040;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] CORE_A = 2'h0;
  localparam logic [1:0] CORE_B = 2'h1;
  localparam logic [1:0] CORE_C = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FG_CAL = 3'b001,
    ST_FG_OFFSET = 3'b010,
    ST_BG_SLEEP = 3'b011,
    ST_BG_WAKE = 3'b100,
    ST_BG_CAL = 3'b101,
    ST_BG_SWAP = 3'b110
  } cal_state_t;
endpackage : cal_seq_pkg

// [dv/core_model.sv]
// converter core model: three sample streams that never sit at midcode
`timescale 1ns/100ps
module core_model (
  // clock
  input wire logic ref_clk,
  // samples
  output logic [11:0] sample_a,
  output logic [11:0] sample_b,
  output logic [11:0] sample_c
);
  logic [11:0] count_reg = 12'h001;
  // odd values only, so a zero output can only come from the sequencer
  always_ff @(posedge ref_clk) begin
    count_reg <= count_reg + 12'h002;
  end
  assign sample_a = count_reg;
  assign sample_b = count_reg ^ 12'h0F0;
  assign sample_c = count_reg ^ 12'hF00;
endmodule : core_model

// [dv/adc_calibration_sequencer_bench.sv]
// self-checking bench for the calibration sequencer
`timescale 1ns/100ps
module adc_calibration_sequencer_bench;
  localparam int CAL = 4;
  localparam int OFS = 8;
  // arbitrary stand-ins for factory trims
  localparam logic [11:0] FT1 = 12'h5A5;
  localparam logic [11:0] FT2 = 12'h3C3;
  localparam logic [7:0] STAT = cal_seq_pkg::ADDR_STATUS;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] aw = 8'h00;
  logic [7:0] ar = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0, pin = 1'b0;
  logic awr, wrd, bv, arr, rv;
  logic [1:0] br, rr, resp;
  logic [31:0] rd, v;
  logic [11:0] sa, sb, sc, d1, d2, t1, t2;
  logic [11:0] e1 = 12'h0;
  logic [11:0] e2 = 12'h0;
  logic [2:0] pwr, cal, sel;
  int errors = 0, checks_done = 0, cyc = 0;

  core_model core_model_i (.ref_clk(ref_clk), .sample_a(sa), .sample_b(sb), .sample_c(sc));
  adc_calibration_sequencer #(.CAL_CYCLES(CAL), .OFFSET_CAL_CYCLES(OFS),
    .FACTORY_TRIM_FIRST(FT1), .FACTORY_TRIM_SECOND(FT2)) adc_calibration_sequencer_i (
    .ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .cal_trigger_pin(pin),
    .sample_core_a(sa), .sample_core_b(sb), .sample_core_c(sc),
    .offset_estimate_first(e1), .offset_estimate_second(e2), .core_power_on(pwr),
    .core_cal_active(cal), .core_input_sel(sel), .data_out_first(d1),
    .data_out_second(d2), .input_offset_trim_first(t1), .input_offset_trim_second(t2));

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // bready is held high, so a response is taken at the first edge it stands
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do @(negedge ref_clk); while (awr !== 1'b1);
    @(posedge ref_clk);
    awv <= 1'b0;
    wv <= 1'b0;
    do @(negedge ref_clk); while (bv !== 1'b1);
    resp = br;
    @(posedge ref_clk);
  endtask : wr
  task automatic rdt(input logic [7:0] a);
    ar <= a;
    arv <= 1'b1;
    do @(negedge ref_clk); while (arr !== 1'b1);
    @(posedge ref_clk);
    arv <= 1'b0;
    do @(negedge ref_clk); while (rv !== 1'b1);
    v = rd;
    resp = rr;
    @(posedge ref_clk);
  endtask : rdt
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h83BC));
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk("powerup_midcode", 32'h0, d1);
    chk("trim_first_reset", FT1, t1);
    chk("trim_second_reset", FT2, t2);
    chk("input_sel", 32'h2, {29'h0, sel});
    repeat (CAL) @(posedge ref_clk);
    rdt(STAT);
    chk("powerup_done", 32'h1, v[0]);
    wr(cal_seq_pkg::ADDR_TRIM_FIRST, 32'h0000_0ABC);
    rdt(cal_seq_pkg::ADDR_TRIM_FIRST);
    chk("trim_rw", 32'h0000_0ABC, v);
    $display("test reset and trims done");
    for (int s = 0; s < 2; s++) begin
      e1 <= 12'($urandom());
      e2 <= 12'($urandom());
      wr(cal_seq_pkg::ADDR_CTRL, 32'h21 | (s << 2));
      if (s == 1) begin
        pin <= 1'b1;
        repeat (2) @(posedge ref_clk);
        pin <= 1'b0;
      end else wr(cal_seq_pkg::ADDR_TRIGGER, 32'h1);
      rdt(STAT);
      chk("done_cleared", 32'h0, v[0]);
      @(negedge ref_clk);
      chk("run_midcode", 32'h0, d2);
      @(posedge ref_clk);
      wr(cal_seq_pkg::ADDR_TRIM_SECOND, 32'h0000_0123);
      repeat (CAL + OFS) @(posedge ref_clk);
      rdt(STAT);
      chk("done_set", 32'h1, v[0]);
      rdt(cal_seq_pkg::ADDR_TRIM_FIRST);
      chk("offset_first", {20'h0, e1}, v);
      rdt(cal_seq_pkg::ADDR_TRIM_SECOND);
      chk("offset_second", {20'h0, e2}, v);
      $display("test foreground source %0d done", s);
    end
    rdt(8'h40);
    chk("unmapped_resp", {30'h0, cal_seq_pkg::RESP_SLVERR}, {30'h0, resp});
    chk("unmapped_data", 32'h0, v);
    wr(cal_seq_pkg::ADDR_CTRL, 32'h03);
    for (int i = 0; i < 200 && cal === 3'h0; i++) @(negedge ref_clk);
    chk("bg_core_cal", 32'h1, 32'(cal !== 3'h0));
    @(negedge ref_clk);
    chk("bg_data_flows", 32'h1, 32'(d1 !== 12'h0));
    @(posedge ref_clk);
    wr(cal_seq_pkg::ADDR_CTRL, 32'h0B);
    repeat (30) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("lp_core_asleep", 32'h1, 32'(pwr !== 3'h7));
    $display("test background done");
    @(posedge ref_clk);
    end_of_test();
  end
endmodule : adc_calibration_sequencer_bench
